//--- hw/link_ctl_params.svh
// Constants for the port link control and status register block.
// Assumes inclusion by the design file only; the package does not include it.
`ifndef LINK_CTL_PARAMS_SVH
`define LINK_CTL_PARAMS_SVH

// Register map, byte addresses on the AXI4-Lite bus
`define LCS_ADDR_W 12
`define LCS_LINK_OFF 12'h0D0

// Control field positions
`define LCS_ASPM_LSB 0
`define LCS_RCB_BIT 3
`define LCS_DIS_BIT 4
`define LCS_RETRAIN_BIT 5
`define LCS_CCLK_BIT 6
`define LCS_XSYNC_BIT 7
`define LCS_HWAW_BIT 9
`define LCS_BWM_BIT 10
`define LCS_BWA_BIT 11

// Status field positions
`define LCS_SPEED_LSB 16
`define LCS_WIDTH_LSB 20
`define LCS_TERR_BIT 26
`define LCS_TRAIN_BIT 27
`define LCS_SLOT_CLOCK_STRAP_BIT 28
`define LCS_DLA_BIT 29

// Status reset values
`define LCS_SPEED_RST 4'h2
`define LCS_WIDTH_RST 6'h01

// Ordered set counts for exit from low power
`define LCS_FTS_EXT 13'h1000
`define LCS_FTS_NORM 13'h0080
`define LCS_TS1_EXT 13'h0400
`define LCS_TS1_NORM 13'h0010

// AXI response codes
`define LCS_RESP_OKAY 2'h0
`define LCS_RESP_SLVERR 2'h2

`endif

//--- hw/link_ctl_pkg.sv
// Types shared by the link control block and its surroundings.
// Assumes the constants header sits beside this file.
package link_ctl_pkg;

  // Software controlled link fields
  typedef struct packed {
    logic [1:0] aspm;
    logic link_disable;
    logic common_clk;
    logic ext_sync;
    logic hw_width_dis;
    logic bw_mgmt_ie;
    logic bw_auto_ie;
  } link_ctrl_t;

  // Report from the link training logic
  typedef struct packed {
    logic [3:0] speed;
    logic [5:0] width;
    logic train_start;
    logic train_done;
    logic train_fail;
    logic dl_active;
  } link_stat_in_t;

  typedef enum logic {WR_IDLE, WR_RESP} wr_state_t;

endpackage

//--- hw/pcie_port_link_control_status.sv
// Link control and status dword of one switch port, AXI4-Lite slave.
// Assumes the training logic reports through link_stat_i, synchronous to aclk,
// and both straps are stable while aresetn is low.
//
// Overview of operation
// R1 - ASPM field decodes L0s and L1 entry
// R2 - Receiver may always enter L0s
// R3 - Completion boundary bit reads zero
// R4 - Upstream link disable fixed at zero
// R5 - Downstream link disable holds link down
// R6 - Downstream retrain starts training; upstream zero
// R7 - Common clock bit writable, reads zero
// R8 - Extended sync sends 4096 FTS sets
// R9 - Extended sync sends 1024 TS1 sets
// R10 - Bandwidth interrupt enables only on downstream
// R11 - Speed field reports negotiated rate
// R12 - Width field reports negotiated lanes
// R13 - Training error set on fail, cleared
// R14 - Training flag high during training
// R15 - Slot clock bit resets to strap
// R16 - Sideband load overrides slot clock bit
// R17 - Data link active mirrors active state
// R18 - Retrain is one-cycle trigger, flag rises
// R19 - Reserved bits read zero, ignore writes
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "link_ctl_params.svh"

module pcie_port_link_control_status
  import link_ctl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic port_upstream_strap,
  input wire logic slot_clock_strap,
  input wire logic sideband_slot_clk_load,
  input wire logic sideband_slot_clk_value,
  input wire link_stat_in_t link_stat_i,
  output link_ctrl_t link_ctrl_o,
  output logic retrain_req,
  output logic l0s_entry_en,
  output logic l1_entry_en,
  output logic rx_l0s_allowed,
  output logic [12:0] fts_exit_count,
  output logic [12:0] ts1_exit_count
);

  // ***************************************************************
  // Decode helpers
  // ***************************************************************

  // True when a byte address selects the link dword
  function automatic logic addr_hit(input logic [11:0] addr);
    addr_hit = (addr[11:2] == 10'(`LCS_LINK_OFF >> 2));
  endfunction

  // ***************************************************************
  // State
  // ***************************************************************

  wr_state_t wr_state_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic upstream_q;
  link_ctrl_t ctrl_q;
  logic retrain_q;
  logic l0s_en_q;
  logic l1_en_q;
  logic rx_l0s_q;
  logic [12:0] fts_q;
  logic [12:0] ts1_q;
  logic [3:0] speed_q;
  logic [5:0] width_q;
  logic train_err_q;
  logic training_q;
  logic slot_clk_q;
  logic dl_active_q;
  logic wr_both;
  logic wr_fire;
  logic [31:0] read_word;

  // Outputs straight from flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign link_ctrl_o = ctrl_q;
  assign retrain_req = retrain_q;
  assign l0s_entry_en = l0s_en_q;
  assign l1_entry_en = l1_en_q;
  assign rx_l0s_allowed = rx_l0s_q;
  assign fts_exit_count = fts_q;
  assign ts1_exit_count = ts1_q;

  // ***************************************************************
  // AXI4-Lite write channel
  // ***************************************************************

  // Address and data both held, response not yet posted
  assign wr_both = (wr_state_q == WR_IDLE) && !awready_q && !wready_q;
  assign wr_fire = wr_both && addr_hit(awaddr_q);

  // Take address and data in either order, then answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= WR_IDLE;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `LCS_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (awvalid && awready_q) begin
        awaddr_q <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready_q <= 1'b0;
      end
      unique case (wr_state_q)
        WR_IDLE: begin
          if (wr_both) begin
            bvalid_q <= 1'b1;
            bresp_q <= addr_hit(awaddr_q) ? `LCS_RESP_OKAY : `LCS_RESP_SLVERR;
            wr_state_q <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            wr_state_q <= WR_IDLE;
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // AXI4-Lite read channel
  // ***************************************************************

  // Dword as software sees it
  always_comb begin
    read_word = '0; // R19
    read_word[`LCS_ASPM_LSB +: 2] = ctrl_q.aspm;
    read_word[`LCS_RCB_BIT] = 1'b0; // R3
    read_word[`LCS_DIS_BIT] = ctrl_q.link_disable;
    read_word[`LCS_RETRAIN_BIT] = 1'b0;
    read_word[`LCS_CCLK_BIT] = 1'b0; // R7
    read_word[`LCS_XSYNC_BIT] = ctrl_q.ext_sync;
    read_word[`LCS_HWAW_BIT] = ctrl_q.hw_width_dis;
    read_word[`LCS_BWM_BIT] = ctrl_q.bw_mgmt_ie;
    read_word[`LCS_BWA_BIT] = ctrl_q.bw_auto_ie;
    read_word[`LCS_SPEED_LSB +: 4] = speed_q; // R11
    read_word[`LCS_WIDTH_LSB +: 6] = width_q; // R12
    read_word[`LCS_TERR_BIT] = train_err_q;
    read_word[`LCS_TRAIN_BIT] = training_q;
    read_word[`LCS_SLOT_CLOCK_STRAP_BIT] = slot_clk_q;
    read_word[`LCS_DLA_BIT] = dl_active_q;
  end

  // One read at a time, answered the cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `LCS_RESP_OKAY;
      rdata_q <= '0;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= addr_hit(araddr) ? `LCS_RESP_OKAY : `LCS_RESP_SLVERR;
      rdata_q <= addr_hit(araddr) ? read_word : 32'h0000_0000;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ***************************************************************
  // Link control fields
  // ***************************************************************

  // Port role caught from its strap while in reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upstream_q <= port_upstream_strap;
    end
  end

  // Software writes, gated by byte lane and port role
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
    end else if (wr_fire) begin
      if (wstrb_q[0]) begin
        ctrl_q.aspm <= wdata_q[`LCS_ASPM_LSB +: 2]; // R1
        ctrl_q.link_disable <= !upstream_q && wdata_q[`LCS_DIS_BIT]; // R4 R5
        ctrl_q.common_clk <= wdata_q[`LCS_CCLK_BIT]; // R7
        ctrl_q.ext_sync <= wdata_q[`LCS_XSYNC_BIT];
      end
      if (wstrb_q[1]) begin
        ctrl_q.hw_width_dis <= wdata_q[`LCS_HWAW_BIT];
        ctrl_q.bw_mgmt_ie <= !upstream_q && wdata_q[`LCS_BWM_BIT]; // R10
        ctrl_q.bw_auto_ie <= !upstream_q && wdata_q[`LCS_BWA_BIT]; // R10
      end
    end
  end

  // Retrain trigger, one cycle per write on a downstream port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retrain_q <= 1'b0;
    end else begin
      retrain_q <= wr_fire && wstrb_q[0] && wdata_q[`LCS_RETRAIN_BIT] && !upstream_q; // R6 R18
    end
  end

  // Low power entry decode and ordered set counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      l0s_en_q <= 1'b0;
      l1_en_q <= 1'b0;
      rx_l0s_q <= 1'b1;
      fts_q <= `LCS_FTS_NORM;
      ts1_q <= `LCS_TS1_NORM;
    end else begin
      l0s_en_q <= ctrl_q.aspm[0]; // R1
      l1_en_q <= ctrl_q.aspm[1]; // R1
      rx_l0s_q <= 1'b1; // R2
      fts_q <= ctrl_q.ext_sync ? `LCS_FTS_EXT : `LCS_FTS_NORM; // R8
      ts1_q <= ctrl_q.ext_sync ? `LCS_TS1_EXT : `LCS_TS1_NORM; // R9
    end
  end

  // ***************************************************************
  // Link status fields
  // ***************************************************************

  // Negotiated rate, width and data link state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_q <= `LCS_SPEED_RST;
      width_q <= `LCS_WIDTH_RST;
      dl_active_q <= 1'b0;
    end else begin
      speed_q <= link_stat_i.speed; // R11
      width_q <= link_stat_i.width; // R12
      dl_active_q <= link_stat_i.dl_active; // R17
    end
  end

  // Training error: set wins over the clear on reaching L0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      train_err_q <= 1'b0;
    end else if (link_stat_i.train_fail) begin
      train_err_q <= 1'b1; // R13
    end else if (link_stat_i.train_done) begin
      train_err_q <= 1'b0; // R13
    end
  end

  // Training in progress, raised also by a retrain request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      training_q <= 1'b0;
    end else if (link_stat_i.train_start || retrain_q) begin
      training_q <= 1'b1; // R14 R18
    end else if (link_stat_i.train_done || link_stat_i.train_fail) begin
      training_q <= 1'b0; // R14
    end
  end

  // Slot clock from strap, replaceable by a sideband load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_clk_q <= slot_clock_strap; // R15
    end else if (sideband_slot_clk_load) begin
      slot_clk_q <= sideband_slot_clk_value; // R16
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_aspm_decode;
    ##1 (l0s_en_q == $past(ctrl_q.aspm[0])) && (l1_en_q == $past(ctrl_q.aspm[1]));
  endproperty
  a_aspm_decode: assert property (p_aspm_decode) else $error("ASPM decode wrong"); // R1

  property p_rx_l0s;
    ##1 rx_l0s_q;
  endproperty
  a_rx_l0s: assert property (p_rx_l0s) else $error("Receiver L0s blocked"); // R2

  property p_reserved_read;
    rvalid_q |-> (rdata_q[3:2] == 2'b00) && (rdata_q[6:5] == 2'b00) && (rdata_q[8] == 1'b0) &&
      (rdata_q[15:12] == 4'h0) && (rdata_q[31:30] == 2'b00);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("Fixed zero bit read set"); // R3

  property p_up_fixed;
    upstream_q |-> !ctrl_q.link_disable && !retrain_q && !ctrl_q.bw_mgmt_ie && !ctrl_q.bw_auto_ie;
  endproperty
  a_up_fixed: assert property (p_up_fixed) else $error("Upstream fixed bit set"); // R4

  property p_disable_write;
    (wr_fire && wstrb_q[0] && !upstream_q) |=> (ctrl_q.link_disable == $past(wdata_q[`LCS_DIS_BIT]));
  endproperty
  a_disable_write: assert property (p_disable_write) else $error("Link disable not written"); // R5

  property p_retrain_pulse;
    (wr_fire && wstrb_q[0] && wdata_q[`LCS_RETRAIN_BIT] && !upstream_q) |=> retrain_q ##1 (!retrain_q && training_q);
  endproperty
  a_retrain_pulse: assert property (p_retrain_pulse) else $error("Retrain trigger wrong"); // R18

  property p_ext_counts;
    ctrl_q.ext_sync ##1 ctrl_q.ext_sync |-> (fts_q == `LCS_FTS_EXT) && (ts1_q == `LCS_TS1_EXT);
  endproperty
  a_ext_counts: assert property (p_ext_counts) else $error("Extended sync counts wrong"); // R8

  property p_err_set;
    link_stat_i.train_fail |=> train_err_q && (training_q == ($past(link_stat_i.train_start) || $past(retrain_q)));
  endproperty
  a_err_set: assert property (p_err_set) else $error("Training error not set"); // R13

  property p_dl_active;
    ##1 (dl_active_q == $past(link_stat_i.dl_active));
  endproperty
  a_dl_active: assert property (p_dl_active) else $error("Data link active not mirrored"); // R17

  c_write: cover property (wr_fire ##[1:4] (bvalid_q && bready));
  c_read: cover property ((arvalid && arready_q) ##1 (rvalid_q && rready));
  c_retrain: cover property (retrain_q ##[1:20] link_stat_i.train_done);

endmodule

//--- verification/link_train_model.sv
// Behavioural link training logic facing the link control block.
// Assumes aclk and aresetn of the block; start and fail commands come from the bench, retrain and link disable from the block.
`timescale 1ns/1ps
module link_train_model
  import link_ctl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic retrain_req,
  input wire logic link_disable,
  input wire logic start_cmd,
  input wire logic fail_mode,
  input wire logic [3:0] speed_i,
  input wire logic [5:0] width_i,
  output link_stat_in_t stat_o
);
  logic [4:0] cnt_q;
  logic st_q, dn_q, fl_q, up_q;

  // ****
  // Training runs 20 cycles, then ends in success or failure
  // ****
  always_ff @(posedge aclk) begin
    st_q <= start_cmd;
    dn_q <= 1'b0;
    fl_q <= 1'b0;
    if (!aresetn) begin
      cnt_q <= 5'h00;
    end else if (retrain_req || start_cmd) begin
      cnt_q <= 5'h14;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
      dn_q <= (cnt_q == 5'h01) && !fail_mode;
      fl_q <= (cnt_q == 5'h01) && fail_mode;
    end
  end

  // Link up after success, down on failure or disable
  always_ff @(posedge aclk) begin
    if (!aresetn || link_disable || fl_q) begin
      up_q <= 1'b0;
    end else if (dn_q) begin
      up_q <= 1'b1;
    end
  end

  assign stat_o = {speed_i, width_i, st_q, dn_q, fl_q, up_q};
endmodule

//--- verification/pcie_port_link_control_status_tb.sv
// Self-checking bench for the port link control and status dword.
// Assumes the package, the design and the training model compile first.
`timescale 1ns/1ps
module pcie_port_link_control_status_tb;
  import link_ctl_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic up_strap, slot_strap, sb_load, sb_val, start_cmd, fail_mode, retrain_req, l0s_en, l1_en, rx_l0s;
  logic [3:0] speed;
  logic [5:0] width;
  logic [12:0] fts_cnt, ts1_cnt;
  link_stat_in_t stat;
  link_ctrl_t ctrl;
  int err_total, n_tests, cyc, n_retrain, n0;

  pcie_port_link_control_status dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .port_upstream_strap(up_strap), .slot_clock_strap(slot_strap), .sideband_slot_clk_load(sb_load),
    .sideband_slot_clk_value(sb_val), .link_stat_i(stat), .link_ctrl_o(ctrl), .retrain_req(retrain_req),
    .l0s_entry_en(l0s_en), .l1_entry_en(l1_en), .rx_l0s_allowed(rx_l0s), .fts_exit_count(fts_cnt),
    .ts1_exit_count(ts1_cnt));
  link_train_model partner (.aclk(aclk), .aresetn(aresetn), .retrain_req(retrain_req),
    .link_disable(ctrl.link_disable), .start_cmd(start_cmd), .fail_mode(fail_mode), .speed_i(speed),
    .width_i(width), .stat_o(stat));

  // ****
  // Clock, retrain pulse count and hang guard
  // ****
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (retrain_req === 1'b1) n_retrain <= n_retrain + 1;
    if (cyc == 4000) begin
      err_total = err_total + 1;
      finish_test;
    end
  end

  // ****
  // Bus cycles and comparison
  // ****
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic do_reset(input logic up, input logic slot);
    aresetn <= 1'b0;
    up_strap <= up;
    slot_strap <= slot;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // Address and data offered together, each dropped when taken; an idle edge follows each transfer
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [31:0] d);
    axi_wr(12'h0D0, d, resp);
    chk("bresp", resp, 32'h0);
  endtask
  task automatic rd_reg;
    axi_rd(12'h0D0, rd, resp);
    chk("rresp", resp, 32'h0);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rd_reg;
    chk("reset dword", rd, 32'h1012_0000);
    chk("fts count", fts_cnt, 32'h80);
    chk("ts1 count", ts1_cnt, 32'h10);
    $display("test reset done");
  endtask
  task automatic t_aspm;
    for (int i = 0; i < 4; i++) begin
      wr(i);
      rd_reg;
      chk("aspm", rd[15:0], i);
      chk("l0s entry", l0s_en, i % 2);
      chk("l1 entry", l1_en, i / 2);
      chk("rx l0s", rx_l0s, 32'h1);
    end
    $display("test aspm done");
  endtask
  task automatic t_ctrl;
    wr(32'hFFFF_FFFF);
    rd_reg;
    chk("ctrl half", rd[15:0], 32'h0E93);
    chk("status top", rd[31:30], 32'h0);
    chk("common clock", ctrl.common_clk, 32'h1);
    chk("fts count", fts_cnt, 32'h1000);
    chk("ts1 count", ts1_cnt, 32'h400);
    wr(32'h0);
    rd_reg;
    chk("fts count", fts_cnt, 32'h80);
    $display("test control done");
  endtask
  // Retrain: success, failure, recovery, then disable
  task automatic t_train;
    repeat (30) @(posedge aclk);
    n0 = n_retrain;
    wr(32'h20);
    rd_reg;
    chk("training", rd[27], 32'h1);
    chk("retrain pulses", n_retrain - n0, 32'h1);
    repeat (30) @(posedge aclk);
    rd_reg;
    chk("trained", rd[29:26], 32'hC);
    fail_mode <= 1'b1;
    wr(32'h20);
    repeat (30) @(posedge aclk);
    rd_reg;
    chk("failed", rd[29:26], 32'h5);
    fail_mode <= 1'b0;
    wr(32'h20);
    repeat (30) @(posedge aclk);
    rd_reg;
    chk("recovered", rd[29:26], 32'hC);
    wr(32'h10);
    rd_reg;
    chk("disabled", rd[29], 32'h0);
    chk("link down", ctrl.link_disable, 32'h1);
    wr(32'h0);
    $display("test training done");
  endtask
  task automatic t_status;
    speed <= 4'h1;
    width <= 6'h04;
    start_cmd <= 1'b1;
    @(posedge aclk);
    start_cmd <= 1'b0;
    sb_val <= 1'b0;
    sb_load <= 1'b1;
    @(posedge aclk);
    sb_load <= 1'b0;
    rd_reg;
    chk("speed width", rd[25:16], 32'h041);
    chk("training", rd[27], 32'h1);
    chk("slot clock", rd[28], 32'h0);
    speed <= 4'h2;
    width <= 6'h01;
    repeat (30) @(posedge aclk);
    $display("test status done");
  endtask
  task automatic t_unmapped;
    axi_wr(12'h0D4, 32'hFFFF, resp);
    chk("bresp", resp, 32'h2);
    axi_rd(12'h0D4, rd, resp);
    chk("rresp", resp, 32'h2);
    chk("rdata", rd, 32'h0);
    rd_reg;
    chk("ctrl half", rd[15:0], 32'h0);
    $display("test unmapped done");
  endtask
  task automatic t_upstream;
    do_reset(1'b1, 1'b0);
    n0 = n_retrain;
    wr(32'hFFFF);
    rd_reg;
    chk("up dword", rd, 32'h0012_0283);
    chk("retrain pulses", n_retrain - n0, 32'h0);
    chk("link down", ctrl.link_disable, 32'h0);
    $display("test upstream done");
  endtask

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, sb_load, sb_val, start_cmd, fail_mode} = '0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    speed = 4'h2;
    width = 6'h01;
    do_reset(1'b0, 1'b1);
    t_reset;
    t_aspm;
    t_ctrl;
    t_train;
    t_status;
    t_unmapped;
    t_upstream;
    finish_test;
  end
endmodule
